//--- drive_power_state_velocity.sv
// drive power state machine, report word and velocity setpoint path
`timescale 1ns/1ps
`default_nettype none
`include "drive_cfg.svh"

// What this block does
// RULE1: command bit 0 set moves the drive toward switched on.
// RULE2: command bit 1 set moves the drive toward voltage enabled.
// RULE3: command bit 2 is active low; cleared enters quick halt from operation enabled, power inhibited from ready or switched on.
// RULE4: command bit 3 set moves the drive toward operation enabled.
// RULE5: command bit 7 clears a pending error only if clearing is allowed.
// RULE6: command bit 8 halts motion in the five halt-capable modes.
// RULE7: command bits 4 to 6 and 9 pass to the selected mode.
// RULE8: report bits 0,1,2 show ready, switched on, operation enabled.
// RULE9: report bit 5 reads zero only in quick halt active; the report resets to zero, so it reads zero until the first edge after reset.
// RULE10: report bit 6 reads one in power inhibited state.
// RULE11: report bit 8 shows fieldbus synchronisation.
// RULE12: report bit 9, remote, always reads one; the report resets to zero, so it reads zero until the first edge after reset.
// RULE13: report bit 15 set only operation enabled with closed loop.
// RULE14: not ready state reports x0xx 0000.
// RULE15: power inhibited state reports x1xx 0000.
// RULE16: ready, switched on, enabled report x01x 0001/0011/0111.
// RULE17: quick halt reports x00x 0111; fault reaction x0xx 1111.
// RULE18: fault state reports x0xx 1000.
// RULE19: target below floor is replaced by floor and limit flag set.
// RULE20: target above ceiling is replaced by ceiling and flag set.
// RULE21: each command write is evaluated and the report updated.
module drive_power_state_velocity (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_obj_write,
  input wire logic i_obj_read,
  input wire logic [15:0] i_obj_index,
  input wire logic [7:0] i_obj_subindex,
  input wire logic [31:0] i_obj_wdata,
  output logic o_obj_ack,
  output logic o_obj_error,
  output logic [31:0] o_obj_rdata,
  input wire logic [7:0] i_op_mode,
  input wire logic i_fault,
  input wire logic i_fault_reaction_done,
  input wire logic i_motion_stopped,
  input wire logic i_voltage_present,
  input wire logic i_warning,
  input wire logic i_closed_loop,
  input wire logic i_bus_sync,
  input wire logic signed [15:0] i_velocity_actual,
  output logic [15:0] o_power_state_report,
  output logic signed [15:0] o_velocity_demand,
  output logic o_power_stage_on,
  output logic o_operation_enabled,
  output logic o_halt,
  output logic [3:0] o_mode_specific_bits
);

  // ==========================================================
  // pin synchroniser
  logic sync_meta, sync_pin;

  // bus sync pin passes two flops before use
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_meta <= 1'b0;
      sync_pin <= 1'b0;
    end else begin
      sync_meta <= i_bus_sync;
      sync_pin <= sync_meta;
    end
  end

  // ==========================================================
  // object registers
  logic [15:0] power_state_command, next_power_state_command;
  logic signed [15:0] velocity_target, next_velocity_target;
  logic [31:0] velocity_lower_limit, next_velocity_lower_limit;
  logic [31:0] velocity_upper_limit, next_velocity_upper_limit;
  logic command_fresh, next_command_fresh;
  logic [15:0] command_prev, next_command_prev;
  logic obj_ack, next_obj_ack, obj_error, next_obj_error;
  logic [31:0] obj_rdata, next_obj_rdata;
  logic [15:0] power_state_report;
  logic signed [15:0] velocity_demand;
  logic hit_command, hit_target, hit_floor, hit_ceiling;

  // decode, writes, reads and the one-cycle answer; anything not
  // writable (read-only or unmapped) answers with error
  always_comb begin
    hit_command = (i_obj_index == `IDX_POWER_STATE_COMMAND);
    hit_target = (i_obj_index == `IDX_VELOCITY_TARGET);
    hit_floor = (i_obj_index == `IDX_VELOCITY_LIMITS) &&
                (i_obj_subindex == `SUB_SPEED_FLOOR);
    hit_ceiling = (i_obj_index == `IDX_VELOCITY_LIMITS) &&
                  (i_obj_subindex == `SUB_SPEED_CEILING);
    next_power_state_command = power_state_command;
    next_velocity_target = velocity_target;
    next_velocity_lower_limit = velocity_lower_limit;
    next_velocity_upper_limit = velocity_upper_limit;
    next_command_fresh = 1'b0;
    next_command_prev = command_fresh ? command_prev : power_state_command;
    next_obj_ack = i_obj_write || i_obj_read;
    next_obj_error = 1'b0;
    next_obj_rdata = obj_rdata;
    if (i_obj_write) begin
      if (hit_command) begin
        next_power_state_command = i_obj_wdata[15:0];
        next_command_fresh = 1'b1; // RULE21
      end else if (hit_target) begin
        next_velocity_target = i_obj_wdata[15:0];
      end else if (hit_floor) begin
        next_velocity_lower_limit = i_obj_wdata;
      end else if (hit_ceiling) begin
        next_velocity_upper_limit = i_obj_wdata;
      end else begin
        next_obj_error = 1'b1; // read-only or unmapped
      end
    end else if (i_obj_read) begin
      next_obj_rdata = 32'h0000_0000;
      case (i_obj_index)
        `IDX_POWER_STATE_COMMAND: next_obj_rdata[15:0] = power_state_command;
        `IDX_POWER_STATE_REPORT: next_obj_rdata[15:0] = power_state_report;
        `IDX_VELOCITY_TARGET: next_obj_rdata[15:0] = velocity_target;
        `IDX_VELOCITY_DEMAND: next_obj_rdata[15:0] = velocity_demand;
        `IDX_VELOCITY_ACTUAL: next_obj_rdata[15:0] = i_velocity_actual;
        `IDX_VELOCITY_LIMITS: begin
          case (i_obj_subindex)
            `SUB_LIMIT_COUNT: next_obj_rdata = `LIMIT_COUNT_VALUE;
            `SUB_SPEED_FLOOR: next_obj_rdata = velocity_lower_limit;
            `SUB_SPEED_CEILING: next_obj_rdata = velocity_upper_limit;
            default: next_obj_error = 1'b1;
          endcase
        end
        default: next_obj_error = 1'b1;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      power_state_command <= `RST_POWER_STATE_COMMAND;
      velocity_target <= `RST_VELOCITY_TARGET;
      velocity_lower_limit <= `RST_SPEED_FLOOR;
      velocity_upper_limit <= `RST_SPEED_CEILING;
      command_fresh <= 1'b0;
      command_prev <= `RST_POWER_STATE_COMMAND;
      obj_ack <= 1'b0;
      obj_error <= 1'b0;
      obj_rdata <= 32'h0000_0000;
    end else begin
      power_state_command <= next_power_state_command;
      velocity_target <= next_velocity_target;
      velocity_lower_limit <= next_velocity_lower_limit;
      velocity_upper_limit <= next_velocity_upper_limit;
      command_fresh <= next_command_fresh;
      command_prev <= next_command_prev;
      obj_ack <= next_obj_ack;
      obj_error <= next_obj_error;
      obj_rdata <= next_obj_rdata;
    end
  end
  assign o_obj_ack = obj_ack;
  assign o_obj_error = obj_error;
  assign o_obj_rdata = obj_rdata;

  // ==========================================================
  // power state machine
  drive_pkg::power_state_t state;
  drive_pkg::power_state_t next_state;
  logic want_on, want_voltage, quick_halt_n, want_operation, clear_edge;

  // command bits of the latest write
  always_comb begin
    want_on = power_state_command[`CMD_SWITCH_ON]; // RULE1
    want_voltage = power_state_command[`CMD_VOLTAGE_ENABLE]; // RULE2
    quick_halt_n = power_state_command[`CMD_QUICK_HALT_N]; // RULE3
    want_operation = power_state_command[`CMD_OPERATION_ENABLE]; // RULE4
    clear_edge = power_state_command[`CMD_ERROR_CLEAR] &&
                 !command_prev[`CMD_ERROR_CLEAR];
  end

  // transitions: faults at once, commands on a fresh write
  always_comb begin
    next_state = state;
    case (state)
      drive_pkg::ST_NOT_READY: next_state = drive_pkg::ST_POWER_INHIBITED;
      drive_pkg::ST_POWER_INHIBITED:
        if (command_fresh && want_voltage && quick_halt_n && !want_on)
          next_state = drive_pkg::ST_READY_FOR_POWER;
      drive_pkg::ST_READY_FOR_POWER: begin
        if (command_fresh) begin
          if (!want_voltage || !quick_halt_n)
            next_state = drive_pkg::ST_POWER_INHIBITED; // RULE2
          else if (want_on)
            next_state = drive_pkg::ST_SWITCHED_ON; // RULE1
        end
      end
      drive_pkg::ST_SWITCHED_ON: begin
        if (command_fresh) begin
          if (!want_voltage || !quick_halt_n)
            next_state = drive_pkg::ST_POWER_INHIBITED;
          else if (!want_on)
            next_state = drive_pkg::ST_READY_FOR_POWER;
          else if (want_operation)
            next_state = drive_pkg::ST_OPERATION_ENABLED; // RULE4
        end
      end
      drive_pkg::ST_OPERATION_ENABLED: begin
        if (command_fresh) begin
          if (!want_voltage)
            next_state = drive_pkg::ST_POWER_INHIBITED;
          else if (!quick_halt_n)
            next_state = drive_pkg::ST_QUICK_HALT_ACTIVE; // RULE3
          else if (!want_on)
            next_state = drive_pkg::ST_READY_FOR_POWER;
          else if (!want_operation)
            next_state = drive_pkg::ST_SWITCHED_ON;
        end
      end
      drive_pkg::ST_QUICK_HALT_ACTIVE:
        if (i_motion_stopped || (command_fresh && !want_voltage))
          next_state = drive_pkg::ST_POWER_INHIBITED;
      drive_pkg::ST_FAULT_REACTION:
        if (i_fault_reaction_done)
          next_state = drive_pkg::ST_FAULT;
      drive_pkg::ST_FAULT:
        if (command_fresh && clear_edge && !i_fault)
          next_state = drive_pkg::ST_POWER_INHIBITED; // RULE5
      default: next_state = drive_pkg::ST_NOT_READY;
    endcase
    if (i_fault && (state != drive_pkg::ST_FAULT_REACTION) &&
        (state != drive_pkg::ST_FAULT))
      next_state = drive_pkg::ST_FAULT_REACTION;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= drive_pkg::ST_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // velocity setpoint path
  velocity_limit_if lim ();
  logic internal_limit_flag, next_internal_limit_flag;
  logic halt_capable;
  logic signed [15:0] next_velocity_demand;
  assign lim.target = velocity_target;
  assign lim.speed_floor = velocity_lower_limit;
  assign lim.speed_ceiling = velocity_upper_limit;
  velocity_limiter u_limiter (
    .lim(lim)
  );

  // halt acts only in the halt-capable modes
  assign halt_capable = (i_op_mode == `MODE_PROFILE_POSITION) ||
                        (i_op_mode == `MODE_VELOCITY) ||
                        (i_op_mode == `MODE_PROFILE_VELOCITY) ||
                        (i_op_mode == `MODE_PROFILE_TORQUE) ||
                        (i_op_mode == `MODE_INTERPOLATED);

  // in velocity mode, demand follows the clamped target while enabled and not halted
  always_comb begin
    next_velocity_demand = `RST_VELOCITY_DEMAND;
    next_internal_limit_flag = 1'b0;
    if (i_op_mode == `MODE_VELOCITY) begin
      next_internal_limit_flag = lim.limited; // RULE19 RULE20
      if ((state == drive_pkg::ST_OPERATION_ENABLED) &&
          !(halt_capable && power_state_command[`CMD_HALT])) // RULE6
        next_velocity_demand = lim.clamped; // RULE19 RULE20
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      velocity_demand <= `RST_VELOCITY_DEMAND;
      internal_limit_flag <= 1'b0;
    end else begin
      velocity_demand <= next_velocity_demand;
      internal_limit_flag <= next_internal_limit_flag;
    end
  end

  // ==========================================================
  // report word
  logic [15:0] next_power_state_report;

  // state patterns plus condition flags
  always_comb begin
    next_power_state_report = 16'h0000;
    next_power_state_report[`RPT_QUICK_HALT_N] = 1'b1; // RULE9
    case (state)
      drive_pkg::ST_NOT_READY: ; // RULE14
      drive_pkg::ST_POWER_INHIBITED:
        next_power_state_report[`RPT_POWER_INHIBITED] = 1'b1; // RULE10 RULE15
      drive_pkg::ST_READY_FOR_POWER:
        next_power_state_report[3:0] = 4'h1; // RULE8 RULE16
      drive_pkg::ST_SWITCHED_ON:
        next_power_state_report[3:0] = 4'h3; // RULE16
      drive_pkg::ST_OPERATION_ENABLED:
        next_power_state_report[3:0] = 4'h7; // RULE16
      drive_pkg::ST_QUICK_HALT_ACTIVE: begin
        next_power_state_report[3:0] = 4'h7; // RULE17
        next_power_state_report[`RPT_QUICK_HALT_N] = 1'b0; // RULE9
      end
      drive_pkg::ST_FAULT_REACTION:
        next_power_state_report[3:0] = 4'hf; // RULE17
      drive_pkg::ST_FAULT:
        next_power_state_report[3:0] = 4'h8; // RULE18
      default: next_power_state_report[3:0] = 4'h0;
    endcase
    next_power_state_report[`RPT_VOLTAGE_APPLIED] = i_voltage_present;
    next_power_state_report[`RPT_WARNING] = i_warning;
    next_power_state_report[`RPT_BUS_SYNC] = sync_pin; // RULE11
    next_power_state_report[`RPT_REMOTE] = 1'b1; // RULE12
    next_power_state_report[`RPT_GOAL_REACHED] =
      (velocity_demand == i_velocity_actual);
    next_power_state_report[`RPT_INTERNAL_LIMIT] = internal_limit_flag;
    next_power_state_report[`RPT_FEEDBACK_LOOP] =
      (state == drive_pkg::ST_OPERATION_ENABLED) && i_closed_loop; // RULE13
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      power_state_report <= `RST_POWER_STATE_REPORT;
    end else begin
      power_state_report <= next_power_state_report; // RULE21
    end
  end

  // ==========================================================
  // outputs toward the drive stages
  logic power_stage_on, next_power_stage_on;
  logic operation_enabled, next_operation_enabled;
  logic halt, next_halt;
  logic [3:0] mode_specific_bits, next_mode_specific_bits;

  // mode bits passed raw; their meaning belongs to the active mode
  always_comb begin
    next_power_stage_on = (state == drive_pkg::ST_SWITCHED_ON) ||
                          (state == drive_pkg::ST_OPERATION_ENABLED) ||
                          (state == drive_pkg::ST_QUICK_HALT_ACTIVE);
    next_operation_enabled = (state == drive_pkg::ST_OPERATION_ENABLED);
    next_halt = halt_capable && power_state_command[`CMD_HALT]; // RULE6
    next_mode_specific_bits = {power_state_command[`CMD_MODE_BIT9],
                               power_state_command[6:4]}; // RULE7
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      power_stage_on <= 1'b0;
      operation_enabled <= 1'b0;
      halt <= 1'b0;
      mode_specific_bits <= 4'h0;
    end else begin
      power_stage_on <= next_power_stage_on;
      operation_enabled <= next_operation_enabled;
      halt <= next_halt;
      mode_specific_bits <= next_mode_specific_bits;
    end
  end
  assign o_power_state_report = power_state_report;
  assign o_velocity_demand = velocity_demand;
  assign o_power_stage_on = power_stage_on;
  assign o_operation_enabled = operation_enabled;
  assign o_halt = halt;
  assign o_mode_specific_bits = mode_specific_bits;

endmodule // drive_power_state_velocity
`default_nettype wire

//--- drive_cfg.svh
// offsets, field positions, reset values and codes of the drive objects
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH

// object indices
`define IDX_POWER_STATE_COMMAND 16'h6040
`define IDX_POWER_STATE_REPORT 16'h6041
`define IDX_VELOCITY_TARGET 16'h6042
`define IDX_VELOCITY_DEMAND 16'h6043
`define IDX_VELOCITY_ACTUAL 16'h6044
`define IDX_VELOCITY_LIMITS 16'h6046
// subindices of the limit array
`define SUB_LIMIT_COUNT 8'h00
`define SUB_SPEED_FLOOR 8'h01
`define SUB_SPEED_CEILING 8'h02
`define LIMIT_COUNT_VALUE 32'h0000_0002

// reset values
`define RST_POWER_STATE_COMMAND 16'h0000
`define RST_POWER_STATE_REPORT 16'h0000
`define RST_VELOCITY_TARGET 16'h00c8
`define RST_VELOCITY_DEMAND 16'h0000
`define RST_SPEED_FLOOR 32'h0000_0000
`define RST_SPEED_CEILING 32'h0000_7530

// command word bit positions
`define CMD_SWITCH_ON 0
`define CMD_VOLTAGE_ENABLE 1
`define CMD_QUICK_HALT_N 2
`define CMD_OPERATION_ENABLE 3
`define CMD_ERROR_CLEAR 7
`define CMD_HALT 8
`define CMD_MODE_BIT9 9

// report word bit positions
`define RPT_READY_FOR_POWER 0
`define RPT_SWITCHED_ON 1
`define RPT_OPERATION_ENABLED 2
`define RPT_FAULT 3
`define RPT_VOLTAGE_APPLIED 4
`define RPT_QUICK_HALT_N 5
`define RPT_POWER_INHIBITED 6
`define RPT_WARNING 7
`define RPT_BUS_SYNC 8
`define RPT_REMOTE 9
`define RPT_GOAL_REACHED 10
`define RPT_INTERNAL_LIMIT 11
`define RPT_FEEDBACK_LOOP 15

// operating mode codes
`define MODE_PROFILE_POSITION 8'h01
`define MODE_VELOCITY 8'h02
`define MODE_PROFILE_VELOCITY 8'h03
`define MODE_PROFILE_TORQUE 8'h04
`define MODE_INTERPOLATED 8'h07

`endif

//--- drive_pkg.sv
// types shared by the drive power state logic
`default_nettype none
package drive_pkg;
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_POWER_INHIBITED,
    ST_READY_FOR_POWER,
    ST_SWITCHED_ON,
    ST_OPERATION_ENABLED,
    ST_QUICK_HALT_ACTIVE,
    ST_FAULT_REACTION,
    ST_FAULT
  } power_state_t;
endpackage
`default_nettype wire

//--- velocity_limit_if.sv
// interface between the drive core and its speed limiter
`timescale 1ns/1ps
`default_nettype none
interface velocity_limit_if;
  logic signed [15:0] target;
  logic [31:0] speed_floor;
  logic [31:0] speed_ceiling;
  logic signed [15:0] clamped;
  logic limited;
  modport owner (output target, speed_floor, speed_ceiling,
    input clamped, limited);
  modport limiter (input target, speed_floor, speed_ceiling,
    output clamped, limited);
endinterface
`default_nettype wire

//--- velocity_limiter.sv
// clamps the magnitude of the target speed between floor and ceiling
`timescale 1ns/1ps
`default_nettype none
module velocity_limiter (
  velocity_limit_if.limiter lim
);
  logic [16:0] magnitude;
  logic [16:0] limit_mag;
  logic negative;

  // magnitude compare, sign of the target kept
  always_comb begin
    negative = lim.target[15];
    magnitude = negative ? 17'(-$signed({lim.target[15], lim.target}))
                         : {1'b0, lim.target};
    limit_mag = magnitude;
    lim.limited = 1'b0;
    if ({15'h0000, magnitude} < lim.speed_floor) begin
      limit_mag = (lim.speed_floor > 32'h0000_7fff) ? 17'h07fff
                                                    : lim.speed_floor[16:0];
      lim.limited = 1'b1; // RULE19
    end else if ({15'h0000, magnitude} > lim.speed_ceiling) begin
      limit_mag = lim.speed_ceiling[16:0];
      lim.limited = 1'b1; // RULE20
    end
    lim.clamped = negative ? 16'(-$signed(limit_mag)) : limit_mag[15:0];
  end
endmodule // velocity_limiter
`default_nettype wire

//--- drive_props.sv
// port checker of the drive power state block
`timescale 1ns/1ps
`default_nettype none
module drive_props (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_obj_write,
  input wire logic i_obj_read,
  input wire logic [15:0] i_obj_index,
  input wire logic [7:0] i_op_mode,
  input wire logic o_obj_ack,
  input wire logic o_obj_error,
  input wire logic [15:0] o_power_state_report,
  input wire logic o_halt
);
  // ==========
  // report and object port checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic up;
  logic [15:0] rpt;
  assign rpt = o_power_state_report;
  // report has loaded once since reset
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn)
      up <= 1'b0;
    else
      up <= 1'b1;
  end
  sequence s_req;
    i_obj_write || i_obj_read;
  endsequence
  sequence s_cmd;
    i_obj_write && i_obj_index == 16'h6040;
  endsequence
  sequence s_ok_ack;
    o_obj_ack && !o_obj_error;
  endsequence
  a_ack_follows: assert property (s_req |=> o_obj_ack)
    else $error("request not answered after one cycle");
  a_cmd_accepted: assert property (
    s_cmd |=> s_ok_ack)
    else $error("command write not accepted");
  a_ro_refused: assert property (i_obj_write &&
    i_obj_index inside {16'h6041, 16'h6043, 16'h6044} |=>
    o_obj_ack && o_obj_error)
    else $error("report write not refused");
  a_remote_set: assert property (up |-> rpt[9])
    else $error("remote bit low");
  a_inhibit_code: assert property (
    up && rpt[6] |-> rpt[3:0] == 4'h0)
    else $error("power inhibited code wrong");
  a_halt_code: assert property (
    up && !rpt[5] |-> rpt[3:0] == 4'h7 && !rpt[6])
    else $error("quick halt code wrong");
  a_enabled_bits: assert property (
    up && rpt[2] |-> rpt[1:0] == 2'b11 && !rpt[6])
    else $error("enabled code wrong");
  a_loop_enabled: assert property (
    rpt[15] |-> rpt[2] && rpt[5])
    else $error("closed loop flag outside enabled");
  a_fault_code: assert property (
    rpt[3] |-> !rpt[6] && rpt[2:0] inside {3'h0, 3'h7})
    else $error("fault code wrong");
  a_halt_mode: assert property (
    o_halt |-> $past(i_op_mode) inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h07})
    else $error("halt in a mode without halt");
endmodule // drive_props
bind drive_power_state_velocity drive_props props_u (.i_clk_sys,
  .i_resetn, .i_obj_write, .i_obj_read, .i_obj_index, .i_op_mode,
  .o_obj_ack, .o_obj_error, .o_power_state_report, .o_halt);
`default_nettype wire

//--- fieldbus_host.sv
// fieldbus host model issuing object reads and writes
`timescale 1ns/1ps
`default_nettype none
module fieldbus_host (
  input wire logic i_clk_sys,
  output logic o_write,
  output logic o_read,
  output logic [15:0] o_index,
  output logic [7:0] o_subindex,
  output logic [31:0] o_wdata,
  input wire logic i_ack,
  input wire logic i_error,
  input wire logic [31:0] i_rdata
);
  // ==========
  // idle request lines
  initial begin
    o_write = 1'b0;
    o_read = 1'b0;
    o_index = 16'h0000;
    o_subindex = 8'h00;
    o_wdata = 32'h0000_0000;
  end
  // one access after gap+1 idle edges; answer taken at the ack edge
  task automatic access(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [31:0] wd, input int gap,
      output logic [31:0] rd, output logic er);
    int n;
    repeat (gap + 1) @(posedge i_clk_sys);
    o_write <= wr;
    o_read <= !wr;
    o_index <= idx;
    o_subindex <= sub;
    o_wdata <= wd;
    @(posedge i_clk_sys);
    o_write <= 1'b0;
    o_read <= 1'b0;
    o_index <= ~idx; // released index and data lines do not keep old values
    o_wdata <= ~wd;
    n = 0;
    @(posedge i_clk_sys);
    while (i_ack !== 1'b1 && n < 8) begin
      @(posedge i_clk_sys);
      n++;
    end
    rd = i_rdata;
    er = (n < 8) ? i_error : 1'bx;
  endtask
endmodule // fieldbus_host
`default_nettype wire

//--- testbench.sv
// self-checking bench of the drive power state block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr, rd, ack, err, fault, frdone, stopped, loop, sync, stage, open;
  logic halt;
  logic [15:0] idx, rpt;
  logic [7:0] sub, mode;
  logic [31:0] wd, rdat;
  logic signed [15:0] demand;
  logic [3:0] msb;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  drive_power_state_velocity dut_u (.i_clk_sys(clk), .i_resetn(rstn),
    .i_obj_write(wr), .i_obj_read(rd), .i_obj_index(idx),
    .i_obj_subindex(sub), .i_obj_wdata(wd), .o_obj_ack(ack),
    .o_obj_error(err), .o_obj_rdata(rdat), .i_op_mode(mode),
    .i_fault(fault), .i_fault_reaction_done(frdone),
    .i_motion_stopped(stopped), .i_voltage_present(1'b1),
    .i_warning(1'b0), .i_closed_loop(loop), .i_bus_sync(sync),
    .i_velocity_actual(16'sh0005), .o_power_state_report(rpt),
    .o_velocity_demand(demand), .o_power_stage_on(stage),
    .o_operation_enabled(open), .o_halt(halt), .o_mode_specific_bits(msb));
  fieldbus_host host_u (.i_clk_sys(clk), .o_write(wr), .o_read(rd),
    .o_index(idx), .o_subindex(sub), .o_wdata(wd), .i_ack(ack),
    .i_error(err), .i_rdata(rdat));
  // ==========
  // helpers
  task automatic chk(input string name, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic sett(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rpt_is(input logic [15:0] mask, exp);
    chk("report", {16'h0, rpt & mask}, {16'h0, exp});
  endtask
  task automatic put(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host_u.access(1'b1, i, s, d, 0, r, e);
    chk("write error", {31'h0, e}, 32'h0);
    sett(3);
  endtask
  task automatic get(input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    host_u.access(1'b0, i, s, 32'h0, 1, r, e);
    chk("read error", {31'h0, e}, {31'h0, xe});
    chk("read data", r, x);
  endtask
  // ==========
  // scenarios
  task automatic t_reset_defaults();
    logic [31:0] r;
    logic e;
    sett(4);
    rpt_is(16'hffff, 16'h0270);
    get(16'h6040, 8'h00, 32'h0, 1'b0);
    get(16'h6042, 8'h00, 32'h00c8, 1'b0);
    get(16'h6046, 8'h00, 32'h0002, 1'b0);
    get(16'h6046, 8'h01, 32'h0, 1'b0);
    get(16'h6046, 8'h02, 32'h7530, 1'b0);
    get(16'h6045, 8'h00, 32'h0, 1'b1);
    host_u.access(1'b1, 16'h6043, 8'h00, 32'h1234, 0, r, e);
    chk("ro write", {31'h0, e}, 32'h1);
    get(16'h6041, 8'h00, 32'h0270, 1'b0);
  endtask
  task automatic t_power_up();
    put(16'h6040, 8'h00, 32'h0006);
    rpt_is(16'h006f, 16'h0021);
    put(16'h6040, 8'h00, 32'h0007);
    rpt_is(16'h006f, 16'h0023);
    put(16'h6040, 8'h00, 32'h000f);
    rpt_is(16'h806f, 16'h0027);
    chk("enabled", {31'h0, open}, 32'h1);
    @(posedge clk) loop <= 1'b1;
    sync <= 1'b1;
    sett(4);
    rpt_is(16'h8100, 16'h8100);
  endtask
  task automatic t_velocity();
    put(16'h6046, 8'h01, 32'h0064);
    put(16'h6046, 8'h02, 32'h1000);
    put(16'h6042, 8'h00, 32'h0010);
    chk("demand", {16'h0, demand}, 32'h0064);
    rpt_is(16'h0800, 16'h0800);
    put(16'h6042, 8'h00, 32'h2000);
    chk("demand", {16'h0, demand}, 32'h1000);
    rpt_is(16'h0800, 16'h0800);
    put(16'h6042, 8'h00, 32'h0800);
    chk("demand", {16'h0, demand}, 32'h0800);
    rpt_is(16'h0800, 16'h0000);
  endtask
  task automatic t_halt_modes();
    logic [7:0] modes [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
    put(16'h6040, 8'h00, 32'h010f);
    foreach (modes[k]) begin
      @(posedge clk) mode <= modes[k];
      sett(3);
      chk("halt", {31'h0, halt}, 32'h1);
    end
    @(posedge clk) mode <= 8'h06;
    sett(3);
    chk("halt", {31'h0, halt}, 32'h0);
    @(posedge clk) mode <= 8'h02;
    put(16'h6040, 8'h00, 32'h025f);
    chk("mode bits", {28'h0, msb}, 32'hd);
  endtask
  task automatic t_quick_halt();
    put(16'h6040, 8'h00, 32'h000b);
    rpt_is(16'h006f, 16'h0007);
    chk("stage on", {31'h0, stage}, 32'h1);
    @(posedge clk) stopped <= 1'b1;
    sett(3);
    rpt_is(16'h006f, 16'h0060);
    @(posedge clk) stopped <= 1'b0;
  endtask
  task automatic t_fault();
    @(posedge clk) fault <= 1'b1;
    sett(3);
    rpt_is(16'h004f, 16'h000f);
    @(posedge clk) frdone <= 1'b1;
    sett(3);
    rpt_is(16'h004f, 16'h0008);
    put(16'h6040, 8'h00, 32'h0000);
    put(16'h6040, 8'h00, 32'h0080);
    rpt_is(16'h004f, 16'h0008);
    @(posedge clk) fault <= 1'b0;
    put(16'h6040, 8'h00, 32'h0000);
    put(16'h6040, 8'h00, 32'h0080);
    rpt_is(16'h004f, 16'h0040);
  endtask
  // ==========
  // run control
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    fault = 1'b0;
    frdone = 1'b0;
    stopped = 1'b0;
    loop = 1'b0;
    sync = 1'b0;
    mode = 8'h02;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset_defaults();
    t_power_up();
    t_velocity();
    t_halt_modes();
    t_quick_halt();
    t_fault();
    final_report();
  end
endmodule // testbench
`default_nettype wire
